/* bhf_framer.sv */
// What this block does
// - Each start/stop request ends with a confirm: success when done, error otherwise; one written while a request is open is dropped with no confirm.
// - Secondary device request that met a negative acknowledge confirms with NACK status.
// - Status codes use the fixed table 0x00 to 0x08.
// - Bit 0 of each field is least significant; leftmost field goes first.
// - Multi-octet fields go out lowest-numbered octet first.
// - Reserved bits are sent as zero and ignored when read back.
// - Header order: param1, address 6, location 8, param2, param3, map 5.
// - Param1: version bits 0-2, priority 3-5, height bit 6, rank bit 7.
// - Frame version is always sent as zero.
// - Priority is a plain number, 7 highest, 0 lowest.
// - Height flag set when the antenna is above 30 metres.
// - Rank flag set for a primary beacon device, clear for secondary.
// - Param2: width bits 0-1, cease bit 2, reserved 3-6, keep-out bit 7.
// - Width codes 0,1,2 for 6,7,8 MHz; code 3 is reserved.
// - Cease flag set only when the unit plans to stop transmitting.
// - Keep-out flag set when the protected radius exceeds 500 m.
// - Param3: indoor flag bit 0, occupancy hours bits 1-7.
// - Indoor flag one for indoor antenna; reset default zero (outdoors).
// - Occupancy hours value zero means indeterminate duration.
// - Start true begins single or periodic beaconing; start false stops it.
// - Map bit 0 chooses channel list (0) or subchannel list (1).
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "bhf_defines.svh"
module bhf_framer (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Octet stream to the PHY
  output logic             phy_valid,
  output bhf_pkg::bhf_octet_t phy_data,
  output logic             phy_first,
  output logic             phy_last,
  input  wire logic        phy_ready,
  // Confirm towards management
  output logic             cnf_valid,
  output logic      [7:0]  cnf_status,
  output logic             beaconing
);
  import bhf_pkg::*;

  // ----------------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------------
  logic        wr_pend;
  logic        rd_pend;
  logic [11:0] a_addr;
  bhf_state_e  state;
  logic [31:0] param;
  logic [47:0] src_addr;
  logic [63:0] location;
  logic [39:0] chan_map;
  logic        req_start;
  logic        req_periodic;
  logic        req_nack;
  logic        busy_flag;
  logic [7:0]  last_status;
  logic [4:0]  idx;
  logic [175:0] hdr;
  bhf_octet_t  hdr_oct [0:21];
  logic [7:0]  next_octet;
  logic        go_wr;

  // Zero-wait slave: every access completes in its data phase
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      a_addr  <= 12'h000;
    end else if (hready) begin
      wr_pend <= hsel & htrans[1] & hwrite;
      rd_pend <= hsel & htrans[1] & ~hwrite;
      a_addr  <= haddr;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // A write to control while a request is open is dropped, not queued
  assign go_wr = wr_pend && (a_addr == `BHF_OFF_CTRL) && hwdata[`BHF_CTRL_GO];

  // ----------------------------------------------------------------------
  // Field registers
  // ----------------------------------------------------------------------
  // Reserved bits are cleared on write so they can never leak out
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      param    <= 32'h0000_0000;
      src_addr <= 48'h0;
      location <= 64'h0;
      chan_map <= 40'h0;
    end else if (wr_pend) begin
      unique case (a_addr)
        `BHF_OFF_PARAM: begin
          param[2:0]   <= `BHF_FRAME_VER;
          param[5:3]   <= hwdata[5:3];
          param[7:6]   <= hwdata[7:6];
          param[9:8]   <= hwdata[9:8];
          param[10]    <= hwdata[10];
          param[14:11] <= 4'h0;
          param[15]    <= hwdata[15];
          param[23:16] <= hwdata[23:16];
          param[31:24] <= 8'h00;
        end
        `BHF_OFF_ADDR_LO: src_addr[31:0]  <= hwdata;
        `BHF_OFF_ADDR_HI: src_addr[47:32] <= hwdata[15:0];
        `BHF_OFF_LOC_LO:  location[31:0]  <= hwdata;
        `BHF_OFF_LOC_HI:  location[63:32] <= hwdata;
        `BHF_OFF_MAP_LO:  chan_map[31:0]  <= hwdata;
        `BHF_OFF_MAP_HI:  chan_map[39:32] <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_start    <= 1'b0;
      req_periodic <= 1'b0;
      req_nack     <= 1'b0;
    end else if (go_wr && state == BHF_IDLE) begin
      req_start    <= hwdata[`BHF_CTRL_START];
      req_periodic <= hwdata[`BHF_CTRL_PERIODIC] & hwdata[`BHF_CTRL_START];
      req_nack     <= hwdata[`BHF_CTRL_NACK];
    end
  end

  // ----------------------------------------------------------------------
  // Header image, field order and bit order
  // ----------------------------------------------------------------------
  // Octet n sits at bits 8n+7..8n; bit 0 of each field is its LSB
  assign hdr = {chan_map, param[23:16], param[15:8], location,
                src_addr, param[7:0]};

  // One tap per header octet, so the sequencer only has to pick by index
  for (genvar g = 0; g < `BHF_HDR_OCTETS; g++) begin : g_oct
    assign hdr_oct[g] = hdr[8*g +: 8];
  end
  assign next_octet = (idx < `BHF_HDR_OCTETS) ? hdr_oct[idx] : 8'h00;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Reserved width code or a refused frame gives an error confirm
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state       <= BHF_IDLE;
      idx         <= 5'd0;
      phy_valid   <= 1'b0;
      phy_data    <= 8'h00;
      phy_first   <= 1'b0;
      phy_last    <= 1'b0;
      cnf_valid   <= 1'b0;
      cnf_status  <= `BHF_ST_SUCCESS;
      last_status <= `BHF_ST_SUCCESS;
      beaconing   <= 1'b0;
      busy_flag   <= 1'b0;
    end else begin
      cnf_valid <= 1'b0;
      unique case (state)
        BHF_IDLE: begin
          if (go_wr) begin
            busy_flag <= 1'b1;
            // Refusals are decided here, so no octet of a refused frame leaves
            if (!hwdata[`BHF_CTRL_START]) begin
              beaconing <= 1'b0;
              state     <= BHF_CONF;
            end else if (param[9:8] == `BHF_WIDTH_RSVD) begin
              state <= BHF_CONF;
            end else if (hwdata[`BHF_CTRL_NACK] && !param[7]) begin
              state <= BHF_CONF;
            end else begin
              idx       <= 5'd0;
              state     <= BHF_SEND;
            end
          end
        end
        BHF_SEND: begin
          // An octet stands until taken; a slow PHY only stretches the frame
          if (!phy_valid || phy_ready) begin
            if (idx == `BHF_HDR_OCTETS) begin
              phy_valid <= 1'b0;
              phy_last  <= 1'b0;
              beaconing <= req_periodic;
              state     <= BHF_CONF;
            end else begin
              phy_valid <= 1'b1;
              phy_data  <= next_octet;
              phy_first <= (idx == 5'd0);
              phy_last  <= (idx == `BHF_HDR_OCTETS - 5'd1);
              idx       <= idx + 5'd1;
            end
          end
        end
        BHF_CONF: begin
          cnf_valid <= 1'b1;
          busy_flag <= 1'b0;
          state     <= BHF_IDLE;
          if (!req_start) begin
            cnf_status  <= `BHF_ST_SUCCESS;
            last_status <= `BHF_ST_SUCCESS;
          end else if (param[9:8] == `BHF_WIDTH_RSVD) begin
            cnf_status  <= `BHF_ST_INVALID_PARAMETER;
            last_status <= `BHF_ST_INVALID_PARAMETER;
          end else if (req_nack && !param[7]) begin
            cnf_status  <= `BHF_ST_NACK;
            last_status <= `BHF_ST_NACK;
          end else begin
            cnf_status  <= `BHF_ST_SUCCESS;
            last_status <= `BHF_ST_SUCCESS;
          end
        end
        default: state <= BHF_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Registered at the address phase, so the word stands for the data phase
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && !hwrite && hready) begin
      unique case (haddr)
        `BHF_OFF_PARAM:   hrdata <= param;
        `BHF_OFF_ADDR_LO: hrdata <= src_addr[31:0];
        `BHF_OFF_ADDR_HI: hrdata <= {16'h0000, src_addr[47:32]};
        `BHF_OFF_LOC_LO:  hrdata <= location[31:0];
        `BHF_OFF_LOC_HI:  hrdata <= location[63:32];
        `BHF_OFF_MAP_LO:  hrdata <= chan_map[31:0];
        `BHF_OFF_MAP_HI:  hrdata <= {24'h000000, chan_map[39:32]};
        `BHF_OFF_STATUS:  hrdata <= {22'h0, beaconing, busy_flag, last_status};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // A confirm is a one-cycle pulse
  one_confirm_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    cnf_valid |=> !cnf_valid
  ) else $error("confirm longer than one cycle");

  // Parameter 1 leads the frame
  order_first_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    phy_valid && phy_first |-> phy_data == param[7:0]
  ) else $error("first octet not param1");

  // The version leaves as zero, whatever software wrote
  ver_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    phy_valid && phy_first |-> phy_data[2:0] == `BHF_FRAME_VER
  ) else $error("frame version not zero");

  // Parameter 2 is on the wire while idx already points past it
  rsvd_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    phy_valid && idx == 5'd16 |-> phy_data[6:3] == 4'h0
  ) else $error("reserved bits set");

  // Width, cease and keep-out sit in their places
  par2_layout_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    phy_valid && idx == 5'd16 |-> phy_data == {param[15], 4'h0, param[10:8]}
  ) else $error("param2 layout wrong");

  // Indoor flag and occupancy hours follow parameter 2
  par3_layout_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    phy_valid && idx == 5'd17 |-> phy_data == param[23:16]
  ) else $error("param3 layout wrong");

  // The map mode bit is the first bit of the first map octet
  map_mode_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    phy_valid && idx == 5'd18 |-> phy_data[0] == chan_map[0]
  ) else $error("map mode bit misplaced");

  // The frame ends with the top octet of the map
  last_map_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    phy_valid && phy_last |-> phy_data == chan_map[39:32]
  ) else $error("last octet not map top");

  // A stalled octet stands, so none is skipped or reordered
  stall_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    phy_valid && !phy_ready |=> phy_valid && $stable(phy_data)
  ) else $error("octet moved while stalled");

  // Nothing reaches the PHY outside a frame
  idle_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    state != BHF_SEND |-> !phy_valid
  ) else $error("octet outside a frame");

  // A refused secondary request reports the negative acknowledge
  nack_stat_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    state == BHF_CONF && req_start && req_nack && !param[7] &&
    param[9:8] != `BHF_WIDTH_RSVD |=> cnf_valid && cnf_status == `BHF_ST_NACK
  ) else $error("nack not reported");

  // A stop always succeeds
  stop_ok_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    state == BHF_CONF && !req_start |=> cnf_valid && !beaconing && cnf_status == 8'h00
  ) else $error("stop not confirmed");

  // A stop ends beaconing at once and sends nothing
  stop_clear_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    state == BHF_IDLE && go_wr && !hwdata[`BHF_CTRL_START] |=> state == BHF_CONF && !beaconing
  ) else $error("stop did not clear beaconing");

  // Only a periodic start leaves beaconing on
  beacon_rise_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(beaconing) |-> req_start && req_periodic
  ) else $error("beaconing without periodic start");

  // Only codes this block can produce
  status_rng_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    cnf_valid |-> cnf_status inside {8'h00, 8'h03, 8'h08}
  ) else $error("bad status code");

  // The reserved width code is an invalid parameter
  width_rsvd_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    state == BHF_CONF && req_start && param[9:8] == 2'h3 |=> cnf_status == 8'h03
  ) else $error("reserved width accepted");

  // Busy is seen by software exactly while a request is open
  busy_track_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    busy_flag == (state != BHF_IDLE)
  ) else $error("busy flag out of step");

  // A go while busy leaves the open request untouched
  refuse_busy_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    go_wr && state != BHF_IDLE |=> $stable(req_start) && $stable(req_periodic) && $stable(req_nack)
  ) else $error("request taken while busy");
endmodule : bhf_framer

/* bhf_defines.svh */
`ifndef BHF_DEFINES_SVH
`define BHF_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BHF_OFF_CTRL    12'h000
`define BHF_OFF_PARAM   12'h004
`define BHF_OFF_ADDR_LO 12'h008
`define BHF_OFF_ADDR_HI 12'h00C
`define BHF_OFF_LOC_LO  12'h010
`define BHF_OFF_LOC_HI  12'h014
`define BHF_OFF_MAP_LO  12'h018
`define BHF_OFF_MAP_HI  12'h01C
`define BHF_OFF_STATUS  12'h020

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define BHF_CTRL_GO       0
`define BHF_CTRL_START    1
`define BHF_CTRL_PERIODIC 2
`define BHF_CTRL_NACK     3

// ----------------------------------------------------------------------
// Header layout and encodings
// ----------------------------------------------------------------------
`define BHF_HDR_OCTETS  5'd22
`define BHF_FRAME_VER   3'h0
`define BHF_ST_SUCCESS             8'h00
`define BHF_ST_ATTRIBUTE_NOT_FOUND 8'h01
`define BHF_ST_COMPLETE            8'h02
`define BHF_ST_INVALID_PARAMETER   8'h03
`define BHF_ST_RX_ON               8'h04
`define BHF_ST_TRX_OFF             8'h05
`define BHF_ST_TX_BUSY             8'h06
`define BHF_ST_TX_ON               8'h07
`define BHF_ST_NACK                8'h08
`define BHF_WIDTH_RSVD  2'h3

`endif

/* bhf_pkg.sv */
package bhf_pkg;
  typedef enum logic [1:0] {
    BHF_IDLE = 2'b00,
    BHF_SEND = 2'b01,
    BHF_CONF = 2'b10
  } bhf_state_e;
  typedef logic [7:0] bhf_octet_t;
endpackage : bhf_pkg

/* bhf_phy_sink.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// PHY octet sink, prompt or slow, recording what it accepts
// ----------------------------------------------------------------------
module bhf_phy_sink (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Octet stream from the framer
  input  wire logic       phy_valid,
  input  wire logic [7:0] phy_data,
  input  wire logic       phy_first,
  input  wire logic       phy_last,
  output logic            phy_ready,
  // Bench control and record
  input  wire logic       slow,
  input  wire logic       clr,
  output logic [7:0]      got [0:31],
  output int              n_got,
  output logic            bad
);
  logic       cyc;
  logic       stalled;
  logic [7:0] held;
  // A slow PHY takes every other cycle, so octets must really stand
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cyc <= 1'b0;
    end else begin
      cyc <= ~cyc;
    end
  end
  assign phy_ready = ~slow | cyc;
  // Record accepted octets; flag wrong frame markers or a moving octet
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      n_got   <= 0;
      bad     <= 1'b0;
      stalled <= 1'b0;
      held    <= 8'h00;
    end else if (clr) begin
      n_got   <= 0;
      bad     <= 1'b0;
    end else begin
      stalled <= phy_valid & ~phy_ready;
      held    <= phy_data;
      if (stalled && phy_data !== held) begin
        bad <= 1'b1;
      end
      if (phy_valid && phy_ready) begin
        got[n_got[4:0]] <= phy_data;
        n_got           <= n_got + 1;
        if (phy_first !== (n_got == 0) || phy_last !== (n_got == 21)) begin
          bad <= 1'b1;
        end
      end
    end
  end
endmodule : bhf_phy_sink

/* test_bhf_framer.sv */
`timescale 1ns/1ps
`include "bhf_defines.svh"
module test_bhf_framer;
  import bhf_pkg::*;
  typedef struct packed {
    logic [7:0] p1, p2, p3;
    logic [3:0] ctrl;
    logic [7:0] st;
    logic       fr, bc, cb;
  } bhf_row_s;
  localparam logic [47:0] SRC = 48'h605040302010;
  localparam logic [63:0] LOC = 64'hF0E0D0C0B0A09080;
  localparam logic [39:0] MAP = 40'h9988776655;  // Bit 0 set: subchannel list
  logic        ref_clk, rstn, hsel, hwrite, hreadyout, hresp, slow, clr;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        phy_valid, phy_first, phy_last, phy_ready, cnf_valid, beaconing, bad;
  bhf_octet_t  phy_data;
  logic [7:0]  cnf_status;
  logic [7:0]  got [0:31];
  bhf_row_s    rows [0:4];
  int          n_got, n_fail, total_checks, n_cnf, cycles, c0;

  bhf_framer bhf_framer_inst (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phy_valid(phy_valid),
    .phy_data(phy_data), .phy_first(phy_first), .phy_last(phy_last), .phy_ready(phy_ready),
    .cnf_valid(cnf_valid), .cnf_status(cnf_status), .beaconing(beaconing));
  bhf_phy_sink bhf_phy_sink_inst (.ref_clk(ref_clk), .rstn(rstn), .phy_valid(phy_valid),
    .phy_data(phy_data), .phy_first(phy_first), .phy_last(phy_last), .phy_ready(phy_ready),
    .slow(slow), .clr(clr), .got(got), .n_got(n_got), .bad(bad));

  // ----------------------------------------------------------------------
  // Clock, confirm counter and hang guard
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Confirms are counted at the falling edge, where they have settled
  always @(negedge ref_clk) begin
    if (cnf_valid === 1'b1) n_cnf++;
  end
  // Whole run needs under a thousand cycles; far beyond that means a hang
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("TB: checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Single word transfer; the master waits for hready, however long
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wait_cnf();
    int k;
    k = 0;
    do begin @(negedge ref_clk); k++; end while (cnf_valid !== 1'b1 && k < 400);
    chk(k < 400, 1);
  endtask : wait_cnf
  function automatic logic [7:0] exp_oct(bhf_row_s r, int i);
    if (i == 0) return r.p1 & 8'hF8;
    if (i < 7) return SRC[8*(i-1) +: 8];
    if (i < 15) return LOC[8*(i-7) +: 8];
    if (i == 15) return r.p2 & 8'h87;
    if (i == 16) return r.p3;
    return MAP[8*(i-17) +: 8];
  endfunction : exp_oct
  task automatic run_row(input bhf_row_s r);
    ahb(1'b1, `BHF_OFF_PARAM, {8'h00, r.p3, r.p2, r.p1});
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    ahb(1'b1, `BHF_OFF_CTRL, {28'h0, r.ctrl});
    wait_cnf();
    chk(cnf_status, r.st);
    chk(n_got, r.fr ? 22 : 0);
    for (int i = 0; i < n_got && i < 32; i++) chk(got[i], exp_oct(r, i));
    chk(bad, 1'b0);
    if (r.cb) chk(beaconing, r.bc);
    ahb(1'b0, `BHF_OFF_STATUS, 32'h0);
    chk(rd[8:0], {1'b0, r.st});
  endtask : run_row

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rstn, hsel, hwrite, slow, clr} = 5'b0;
    {haddr, htrans, hwdata} = '0;
    hsize = 3'b010;
    // Ordinary cases: single, width code 3, secondary refused, periodic with
    // ignored refusal on a primary, then stop
    rows = '{'{8'hFF, 8'h7E, 8'hFF, 4'h3, 8'h00, 1'b1, 1'b0, 1'b1},
             '{8'h00, 8'h03, 8'h00, 4'h3, 8'h03, 1'b0, 1'b0, 1'b0},
             '{8'h3F, 8'h00, 8'h00, 4'hB, 8'h08, 1'b0, 1'b0, 1'b0},
             '{8'hC7, 8'h81, 8'h00, 4'hF, 8'h00, 1'b1, 1'b1, 1'b1},
             '{8'h80, 8'h00, 8'h00, 4'h1, 8'h00, 1'b0, 1'b0, 1'b1}};
    repeat (3) @(posedge ref_clk);
    chk({hreadyout, phy_valid, cnf_valid, beaconing, cnf_status}, 0);
    rstn <= 1'b1;
    @(posedge ref_clk);
    ahb(1'b0, `BHF_OFF_PARAM, 32'h0);
    chk(rd, 0);
    ahb(1'b1, `BHF_OFF_ADDR_LO, SRC[31:0]);
    ahb(1'b1, `BHF_OFF_ADDR_HI, {16'h0, SRC[47:32]});
    ahb(1'b1, `BHF_OFF_LOC_LO, LOC[31:0]);
    ahb(1'b1, `BHF_OFF_LOC_HI, LOC[63:32]);
    ahb(1'b1, `BHF_OFF_MAP_LO, MAP[31:0]);
    ahb(1'b1, `BHF_OFF_MAP_HI, {24'h0, MAP[39:32]});
    ahb(1'b0, `BHF_OFF_MAP_HI, 32'h0);
    chk(rd, {24'h0, MAP[39:32]});
    for (int i = 0; i < 5; i++) run_row(rows[i]);
    // Slow PHY with a second request while busy: one frame, one confirm
    slow <= 1'b1;
    c0 = n_cnf;
    run_row(rows[0]);
    c0 = n_cnf;
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    ahb(1'b1, `BHF_OFF_CTRL, 32'h3);
    ahb(1'b1, `BHF_OFF_CTRL, 32'h7);
    wait_cnf();
    repeat (120) @(negedge ref_clk);
    chk(n_cnf - c0, 1);
    chk(n_got, 22);
    chk({bad, beaconing}, 2'b00);
    // Reset in mid-run while beaconing: everything returns to its default
    ahb(1'b1, `BHF_OFF_CTRL, 32'h7);
    wait_cnf();
    chk(beaconing, 1'b1);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({beaconing, cnf_valid, phy_valid, cnf_status}, 0);
    rstn <= 1'b1;
    @(posedge ref_clk);
    ahb(1'b0, `BHF_OFF_PARAM, 32'h0);
    chk(rd, 0);
    // Unmapped place: write ignored, reads zero, response okay
    ahb(1'b1, 12'h040, 32'hFFFFFFFF);
    ahb(1'b0, 12'h040, 32'h0);
    chk(rd, 0);
    chk(hresp, 1'b0);
    summarize();
  end
endmodule : test_bhf_framer
